/* src/flash_cmd_map.svh */
// Purpose: named constants for the serial flash write/erase sequencer
// Assumes: included by bare name
// Notes:   opcodes, status bit positions, byte framing counts
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define OP_WREN        8'h06
`define OP_VWREN       8'h50
`define OP_WRDI        8'h04
`define OP_WRSR        8'h01
`define OP_PROG        8'h02
`define OP_QPROG       8'h32
`define OP_SWIPE       8'h20
`define OP_HWIPE       8'h52
`define OP_BWIPE       8'hD8
`define OP_RDSR        8'h05
`define BIT_BUSY       0
`define BIT_WLATCH     1
`define BIT_QUAD_EN    1
`define BIT_REG_LOCK   0
`define STAT1_WMASK    8'hFC
`define STAT2_WMASK    8'h7B
`define STAT2_VMASK    8'h40
`define STAT2_OTPMASK  8'h38
`define ADDR_BYTES     3'h3
`define BYTE_BITS      4'h8
`define PAGE_LAST      8'hFF
`define STATUS_WRITE_NS 32'h0000_0064
`define PAGE_WRITE_NS   32'h0000_00C8
`define SMALL_WIPE_NS   32'h0000_012C
`define LARGE_WIPE_NS   32'h0000_0190
`define CLK_NS          32'h0000_0004
`endif

/* src/flash_cmd_pkg.sv */
// Purpose: shared types for the flash sequencer
// Assumes: nothing
// Notes:   none
package flash_cmd_pkg;
  typedef enum logic [2:0] {
    JOB_NONE  = 3'b000,
    JOB_WRSR  = 3'b001,
    JOB_PROG  = 3'b010,
    JOB_SWIPE = 3'b011,
    JOB_LWIPE = 3'b100
  } job_e;
  typedef logic [7:0] byte_t;
endpackage

/* src/byte_link_if.sv */
// Purpose: carrier between byte buffer and sequencer
// Assumes: single clock
// Notes:   valid/ready handshake
`timescale 1ns/1ps
interface byte_link_if;
  logic [7:0] data;   // byte value
  logic       last;   // frame ended after this byte
  logic       valid;  // byte offered
  logic       ready;  // byte taken
  modport src (output data, output last, output valid, input ready);
  modport dst (input data, input last, input valid, output ready);
endinterface

/* src/byte_buf2.sv */
// Purpose: two-entry buffer for received program data bytes
// Assumes: same clock on both sides
// Notes:   stall on the drain side fills it; in_ready drops
`timescale 1ns/1ps
module byte_buf2
  import flash_cmd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)(
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output      logic             in_ready,
  byte_link_if.src              out
);
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  initial if (DEPTH != 2 || WIDTH != 8) $error("byte_buf2 needs 8x2");
  logic [WIDTH-1:0] mem_ff [DEPTH];  // entries
  logic             wp_ff;           // write pointer
  logic             rp_ff;           // read pointer
  logic [1:0]       cnt_ff;          // fill level
  wire              push = in_valid && in_ready;
  wire              pop  = out.valid && out.ready;
  assign in_ready  = (cnt_ff != 2'h2);
  assign out.valid = (cnt_ff != 2'h0);
  assign out.data  = mem_ff[rp_ff];
  assign out.last  = 1'b0;
  // pointer and level update
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      if (push) wp_ff <= ~wp_ff;
      if (pop)  rp_ff <= ~rp_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
  // data store, no reset needed
  always_ff @(posedge CORE_CLK)
  begin
    if (push) mem_ff[wp_ff] <= in_data;
  end
endmodule

/* src/flash_seq.sv */
// Purpose: write-enable, status write, program and erase command sequencer
// Assumes: serial clock sampled by CORE_CLK (250 MHz); clock at most 1/8 core
// Notes:   no array; program/erase are reported on pulse outputs
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module flash_seq
  import flash_cmd_pkg::*;
#(
  parameter int STATUS_WRITE_CYC = (`STATUS_WRITE_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int PAGE_WRITE_CYC   = (`PAGE_WRITE_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int SMALL_WIPE_CYC   = (`SMALL_WIPE_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int LARGE_WIPE_CYC   = (`LARGE_WIPE_NS + `CLK_NS - 1) / `CLK_NS
)(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        CS_N,
  input  wire logic        SCK,
  input  wire logic [3:0]  QUAD_IN,
  input  wire logic        PAGE_PROTECTED,
  input  wire logic        PROG_READY,
  output      logic        SO_OUT,
  output      logic        SO_OE_N,
  output      logic [7:0]  STATUS_ONE,
  output      logic [7:0]  STATUS_TWO,
  output      logic [23:0] OP_ADDR,
  output      logic [2:0]  OP_KIND,
  output      logic        OP_START,
  output      logic [7:0]  PROG_DATA,
  output      logic [7:0]  PROG_OFFS,
  output      logic        PROG_VALID
);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  initial if (STATUS_WRITE_CYC < 1 || PAGE_WRITE_CYC < 1 || SMALL_WIPE_CYC < 1 ||
              LARGE_WIPE_CYC < 1) $error("cycle counts must be positive");
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] s1_ff;      // first stage
  logic [5:0] s2_ff;      // second stage
  logic       sck_d_ff;   // previous sampled clock
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      s1_ff    <= 6'h3F;
      s2_ff    <= 6'h3F;
      sck_d_ff <= 1'b0;
    end
    else
    begin
      s1_ff    <= {CS_N, SCK, QUAD_IN};
      s2_ff    <= s1_ff;
      sck_d_ff <= s2_ff[4];
    end
  end
  wire       cs_n_s = s2_ff[5];
  wire       sck_s  = s2_ff[4];
  wire [3:0] qd_s   = s2_ff[3:0];
  wire       rise   = sck_s && !sck_d_ff && !cs_n_s;
  wire       fall   = !sck_s && sck_d_ff && !cs_n_s;
  // ---------------------------------------------------------------
  // shift state
  // ---------------------------------------------------------------
  logic       cs_d_ff;     // previous chip select
  logic [7:0] shf_ff;      // incoming byte
  logic [3:0] bit_ff;      // bits in current byte
  logic [2:0] nbyte_ff;    // bytes after opcode (saturating)
  logic [7:0] op_ff;       // current opcode
  logic       op_ok_ff;    // opcode captured
  logic [23:0] addr_ff;    // captured address
  logic [7:0] d1_ff;       // first status data byte
  logic [7:0] d2_ff;       // second status data byte
  logic       boundary_ff; // frame at byte boundary
  logic       wel_ff;      // write latch flag
  logic       vwe_ff;      // volatile write permission
  logic       busy_ff;     // self-timed cycle running
  logic [7:0] sr1_ff;      // status byte one stored bits
  logic [7:0] sr2_ff;      // status byte two
  logic [31:0] tmr_ff;     // cycle timer
  job_e       job_ff;      // running job
  logic [7:0] rd_ff;       // status output shifter
  logic [7:0] poff_ff;     // page offset for next byte
  wire        cs_rise = cs_n_s && !cs_d_ff;
  wire        quad    = op_ok_ff && op_ff == `OP_QPROG; // address and data on four lines
  wire [7:0]  nxt_shf = quad ? {shf_ff[3:0], qd_s} : {shf_ff[6:0], qd_s[0]};
  wire [3:0]  step    = quad ? 4'h4 : 4'h1;
  wire [3:0]  nxt_bit = bit_ff + step;
  wire        byte_done = rise && nxt_bit == `BYTE_BITS;
  wire        in_data_phase = nbyte_ff >= `ADDR_BYTES;
  wire        is_prog = op_ff == `OP_PROG || op_ff == `OP_QPROG;
  wire        data_byte = byte_done && op_ok_ff && is_prog && in_data_phase && !busy_ff;
  // buffer between the shifter and the program data port
  logic       buf_ready;
  byte_link_if lnk();
  byte_buf2 u_buf (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .in_data  (nxt_shf),
    .in_valid (data_byte && wel_ff),
    .in_ready (buf_ready),
    .out      (lnk.src)
  );
  assign lnk.ready = PROG_READY;
  logic [7:0] pofs_q_ff [2];  // offsets tracking buffer entries
  logic       pw_ff;          // offset write index
  logic       pr_ff;          // offset read index
  // ---------------------------------------------------------------
  // command decode at frame end
  // ---------------------------------------------------------------
  wire        end_ok  = cs_rise && op_ok_ff && boundary_ff && !busy_ff;
  wire        wr_rdy  = wel_ff && !PAGE_PROTECTED;
  wire        do_wren = end_ok && op_ff == `OP_WREN && nbyte_ff == 3'h0;
  wire        do_wrdi = end_ok && op_ff == `OP_WRDI && nbyte_ff == 3'h0;
  wire        do_vwe  = end_ok && op_ff == `OP_VWREN && nbyte_ff == 3'h0;
  wire        sr_len  = nbyte_ff >= 3'h1 && nbyte_ff <= 3'h3;
  wire        do_sr   = end_ok && op_ff == `OP_WRSR && sr_len;
  wire        sr_nv   = do_sr && wel_ff;
  wire        sr_vol  = do_sr && !wel_ff && vwe_ff;
  wire        do_prog = end_ok && is_prog && nbyte_ff > `ADDR_BYTES && wr_rdy &&
                        (op_ff == `OP_PROG || sr2_ff[`BIT_QUAD_EN]);
  wire        is_wipe = op_ff == `OP_SWIPE || op_ff == `OP_HWIPE || op_ff == `OP_BWIPE;
  wire        do_wipe = end_ok && is_wipe && nbyte_ff == `ADDR_BYTES && wr_rdy;
  // new status values, masked and lock-preserving
  wire [7:0]  sr1_new = (sr1_ff & ~`STAT1_WMASK) | (d1_ff & `STAT1_WMASK);
  wire [7:0]  keep2   = sr_vol ? (`STAT2_OTPMASK | 8'h01) : 8'h00;
  wire [7:0]  m2      = `STAT2_WMASK & ~keep2;
  wire [7:0]  sr2_new = ((sr2_ff & ~m2) | (d2_ff & m2)) | (sr2_ff & `STAT2_OTPMASK);
  wire        sr2_upd = nbyte_ff >= 3'h2;
  wire        tmr_end = busy_ff && tmr_ff == 32'h0000_0001;
  // ---------------------------------------------------------------
  // shifting process
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N || cs_n_s)
    begin
      bit_ff      <= 4'h0;
      nbyte_ff    <= 3'h0;
      op_ok_ff    <= 1'b0;
      boundary_ff <= 1'b1;
    end
    else if (rise)
    begin
      // bits sampled on rising edge, msb first
      shf_ff      <= nxt_shf;
      boundary_ff <= (nxt_bit == `BYTE_BITS);
      bit_ff      <= (nxt_bit == `BYTE_BITS) ? 4'h0 : nxt_bit;
      if (byte_done)
      begin
        if (!op_ok_ff)
        begin
          op_ff    <= nxt_shf;
          op_ok_ff <= 1'b1;
        end
        else if (nbyte_ff != 3'h7)
          nbyte_ff <= nbyte_ff + 3'h1;
      end
    end
  end
  // address and data capture
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      addr_ff <= 24'h00_0000;
      d1_ff   <= 8'h00;
      d2_ff   <= 8'h00;
    end
    else if (byte_done && op_ok_ff)
    begin
      if (op_ff == `OP_WRSR)
      begin
        if (nbyte_ff == 3'h0) d1_ff <= nxt_shf;
        if (nbyte_ff == 3'h1) d2_ff <= nxt_shf;
      end
      else if (!in_data_phase)
        addr_ff <= {addr_ff[15:0], nxt_shf};
    end
  end
  // page offset wraps inside the page
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      poff_ff <= 8'h00;
    else if (byte_done && op_ok_ff && nbyte_ff == 3'h2)
      poff_ff <= nxt_shf;
    else if (data_byte && wel_ff && buf_ready)
      poff_ff <= poff_ff + 8'h01;
  end
  // offsets ride alongside buffered bytes
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      pw_ff <= 1'b0;
      pr_ff <= 1'b0;
    end
    else
    begin
      if (data_byte && wel_ff && buf_ready)
      begin
        pofs_q_ff[pw_ff] <= poff_ff;
        pw_ff            <= ~pw_ff;
      end
      if (lnk.valid && PROG_READY) pr_ff <= ~pr_ff;
    end
  end
  assign PROG_DATA  = lnk.data;
  assign PROG_VALID = lnk.valid;
  assign PROG_OFFS  = pofs_q_ff[pr_ff];
  // ---------------------------------------------------------------
  // latch, status and timed cycle
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      cs_d_ff  <= 1'b1;
      wel_ff   <= 1'b0;
      vwe_ff   <= 1'b0;
      busy_ff  <= 1'b0;
      sr1_ff   <= 8'h00;
      sr2_ff   <= 8'h00;
      tmr_ff   <= 32'h0000_0000;
      job_ff   <= JOB_NONE;
      OP_START <= 1'b0;
      OP_KIND  <= JOB_NONE;
      OP_ADDR  <= 24'h00_0000;
    end
    else
    begin
      cs_d_ff  <= cs_n_s;
      OP_START <= 1'b0;
      if (do_wren) wel_ff <= 1'b1;
      if (do_wrdi) wel_ff <= 1'b0;
      // volatile permission survives only into the next frame
      if (cs_rise && op_ok_ff) vwe_ff <= do_vwe;
      if (sr_nv || sr_vol)
      begin
        sr1_ff <= sr1_new;
        if (sr2_upd) sr2_ff <= sr2_new;
      end
      if (sr_nv)
      begin
        busy_ff <= 1'b1;
        tmr_ff  <= STATUS_WRITE_CYC;
        job_ff  <= JOB_WRSR;
      end
      else if (do_prog || do_wipe)
      begin
        busy_ff  <= 1'b1;
        tmr_ff   <= do_prog ? PAGE_WRITE_CYC :
                    (op_ff == `OP_SWIPE ? SMALL_WIPE_CYC : LARGE_WIPE_CYC);
        job_ff   <= do_prog ? JOB_PROG : (op_ff == `OP_SWIPE ? JOB_SWIPE : JOB_LWIPE);
        OP_START <= 1'b1;
        // half and full block both report the large wipe kind
        OP_KIND  <= do_prog ? JOB_PROG : (op_ff == `OP_SWIPE ? JOB_SWIPE : JOB_LWIPE);
        OP_ADDR  <= (op_ff == `OP_SWIPE) ? {addr_ff[23:12], 12'h000} :
                    (op_ff == `OP_BWIPE) ? {addr_ff[23:16], 16'h0000} :
                    (op_ff == `OP_HWIPE) ? {addr_ff[23:15], 15'h0000} :
                    {addr_ff[23:8], 8'h00};
      end
      else if (busy_ff)
      begin
        tmr_ff <= tmr_ff - 32'h0000_0001;
        if (tmr_end)
        begin
          busy_ff <= 1'b0;
          wel_ff  <= 1'b0;
          job_ff  <= JOB_NONE;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // status read output, driven on falling edge
  // ---------------------------------------------------------------
  wire rdsr = op_ok_ff && op_ff == `OP_RDSR && !cs_n_s;
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N || cs_n_s)
    begin
      rd_ff   <= 8'h00;
      SO_OUT  <= 1'b0;
      SO_OE_N <= 1'b1;
    end
    else if (byte_done && !op_ok_ff && nxt_shf == `OP_RDSR)
      rd_ff <= STATUS_ONE;
    else if (fall && rdsr)
    begin
      SO_OUT  <= rd_ff[7];
      SO_OE_N <= 1'b0;
      rd_ff   <= (bit_ff == 4'h7) ? STATUS_ONE : {rd_ff[6:0], 1'b0};
    end
  end
  assign STATUS_ONE = {sr1_ff[7:2], wel_ff, busy_ff};
  assign STATUS_TWO = sr2_ff;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wel_set_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    do_wren && !busy_ff |=> wel_ff) else $error("latch not set");
  wel_clr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    do_wrdi |=> !wel_ff) else $error("latch not cleared");
  wel_done_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    tmr_end |=> !wel_ff && !busy_ff) else $error("cycle end wrong");
  lock_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (($past(sr2_ff) & `STAT2_OTPMASK) & ~sr2_ff) == 8'h00) else $error("lock bit cleared");
  sr_wel_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(busy_ff) && job_ff == JOB_WRSR |-> $past(wel_ff)) else $error("nv write no latch");
  vol_busy_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    sr_vol && !busy_ff |=> !busy_ff) else $error("busy on volatile");
  byte_one_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    do_sr && nbyte_ff == 3'h1 |=> $stable(sr2_ff)) else $error("byte two touched");
  prog_prot_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    end_ok && is_prog && PAGE_PROTECTED |=> !OP_START) else $error("protected program");
  wipe_busy_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    do_wipe |=> busy_ff && OP_START) else $error("wipe not started");
endmodule

/* verification/spi_host_model.sv */
// Purpose: host model that frames commands on chip select and serial clock
// Assumes: serial clock idles low and runs only inside frames
// Notes:   released data lines toggle rather than hold their last level
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module spi_host_model (
  output logic       CS_N,
  output logic       SCK,
  output logic [3:0] QUAD_IN,
  input  wire logic  SO_OUT,
  input  wire logic  SO_OE_N
);
  localparam logic [7:0] RD_OP = `OP_RDSR; // status poll opcode
  logic [7:0] tx_q [$];                     // bytes of the next frame
  logic [7:0] rx_byte;                      // last polled status
  logic       oe_bad;                       // output seen undriven in a read
  initial
  begin
    CS_N    = 1'b1;
    SCK     = 1'b0;
    QUAD_IN = 4'h5;
    oe_bad  = 1'b0;
  end
  // one clock: data set while low, device samples on the rise
  task automatic unit(input logic [3:0] v);
    QUAD_IN = v;
    #16 SCK = 1'b1;
    #16 SCK = 1'b0;
  endtask
  // opcode serial msb first, then serial bits or nibbles
  task automatic frame(input int cut, input bit quad);
    CS_N = 1'b0;
    #16;
    foreach (tx_q[i])
      for (int k = 7; k >= 0; k--)
        if (!(quad && i > 0)) unit({~QUAD_IN[3:1], tx_q[i][k]});
        else if (k == 7 || k == 3) unit(tx_q[i][k-:4]);
    // stray bits leave the frame off a byte boundary
    for (int k = 0; k < cut; k++) unit({~QUAD_IN[3:1], 1'b1});
    #16 CS_N = 1'b1;
    QUAD_IN = ~QUAD_IN;
    #32;
  endtask
  // status poll, each bit taken late in the high phase
  task automatic read_status();
    CS_N = 1'b0;
    #16;
    for (int k = 7; k >= 0; k--) unit({~QUAD_IN[3:1], RD_OP[k]});
    for (int k = 7; k >= 0; k--)
    begin
      #16 SCK = 1'b1;
      #15 rx_byte[k] = SO_OUT;
      if (SO_OE_N !== 1'b0) oe_bad = 1'b1;
      #1 SCK = 1'b0;
    end
    #16 CS_N = 1'b1;
    #32;
  endtask
endmodule

/* verification/test_serial_flash_write_erase_cmds.sv */
// Purpose: self-checking bench for the flash command sequencer
// Assumes: host model drives the serial pins; short busy spans except the 200-cycle status write
// Notes:   expectations follow the status masks and job codes
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module test_serial_flash_write_erase_cmds
  import flash_cmd_pkg::*;
();
  localparam int SW_CYC = 200; // status write busy span
  localparam int PW_CYC = 7;   // page write busy span
  localparam int SM_CYC = 9;   // 4k wipe busy span
  localparam int LG_CYC = 11;  // large wipe busy span
  logic        CORE_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        PAGE_PROTECTED = 1'b0;
  logic        PROG_READY = 1'b1;
  logic        CS_N, SCK, SO_OUT, SO_OE_N, OP_START, PROG_VALID;
  logic [3:0]  QUAD_IN;
  logic [7:0]  STATUS_ONE, STATUS_TWO, PROG_DATA, PROG_OFFS;
  logic [23:0] OP_ADDR, addr_seen;
  logic [2:0]  OP_KIND, kind_seen;
  logic [15:0] got_q [$];      // offset and data of taken bytes
  int          fail_count = 0;
  int          checks_done = 0;
  int          busy_cyc = 0;   // cycles seen busy
  int          starts = 0;     // job start pulses
  always #2 CORE_CLK = ~CORE_CLK;
  // monitor: busy span, job starts, bytes handed over
  always @(posedge CORE_CLK)
  begin
    if (STATUS_ONE[0] === 1'b1) busy_cyc <= busy_cyc + 1;
    if (OP_START === 1'b1)
    begin
      starts    <= starts + 1;
      kind_seen <= OP_KIND;
      addr_seen <= OP_ADDR;
    end
    if (PROG_VALID === 1'b1 && PROG_READY === 1'b1) got_q.push_back({PROG_OFFS, PROG_DATA});
  end
  flash_seq #(.STATUS_WRITE_CYC(SW_CYC), .PAGE_WRITE_CYC(PW_CYC),
              .SMALL_WIPE_CYC(SM_CYC), .LARGE_WIPE_CYC(LG_CYC)) u_dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CS_N(CS_N), .SCK(SCK), .QUAD_IN(QUAD_IN),
    .PAGE_PROTECTED(PAGE_PROTECTED), .PROG_READY(PROG_READY), .SO_OUT(SO_OUT),
    .SO_OE_N(SO_OE_N), .STATUS_ONE(STATUS_ONE), .STATUS_TWO(STATUS_TWO), .OP_ADDR(OP_ADDR),
    .OP_KIND(OP_KIND), .OP_START(OP_START), .PROG_DATA(PROG_DATA), .PROG_OFFS(PROG_OFFS),
    .PROG_VALID(PROG_VALID));
  spi_host_model u_host (.CS_N(CS_N), .SCK(SCK), .QUAD_IN(QUAD_IN), .SO_OUT(SO_OUT),
                         .SO_OE_N(SO_OE_N));
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic set_in(input logic rdy, input logic prot);
    @(posedge CORE_CLK);
    #1 PROG_READY = rdy;
    PAGE_PROTECTED = prot;
  endtask
  task automatic cmd1(input logic [7:0] op);
    u_host.tx_q = '{op};
    u_host.frame(0, 1'b0);
    repeat (8) @(posedge CORE_CLK);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (STATUS_ONE[0] !== 1'b0 && n < 1000)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    cmp(n < 1000, 1'b1, "busy end");
  endtask
  task automatic chk_sr(input logic [7:0] s1, input logic [7:0] s2);
    cmp(STATUS_ONE, s1, "status one");
    cmp(STATUS_TWO, s2, "status two");
  endtask
  // send queued frame, judge busy span, start pulse, kind and address
  task automatic run_job(input int cut, input bit quad, input bit poll, input int bsy,
                         input job_e kind, input logic [23:0] msk, input logic [23:0] adr);
    int b0;
    int s0;
    b0 = busy_cyc;
    s0 = starts;
    u_host.frame(cut, quad);
    if (poll) u_host.read_status();
    if (poll) cmp(u_host.rx_byte[0], 1'b1, "polled busy");
    repeat (8) @(posedge CORE_CLK);
    wait_idle();
    if (bsy >= 0) cmp(24'(busy_cyc - b0), 24'(bsy), "busy span");
    if (kind != JOB_WRSR) cmp(24'(starts - s0), kind != JOB_NONE, "starts");
    if (kind > JOB_WRSR) cmp(kind_seen, kind, "job kind");
    if (kind > JOB_WRSR) cmp(addr_seen & msk, adr, "job address");
  endtask
  task automatic sc_latch();
    chk_sr(8'h00, 8'h00);
    cmp(SO_OE_N, 1'b1, "idle output");
    cmd1(`OP_WREN);
    chk_sr(8'h02, 8'h00);
    u_host.read_status();
    cmp(u_host.rx_byte, 8'h02, "polled status");
    cmp(u_host.oe_bad, 1'b0, "read enable");
    cmd1(`OP_VWREN);
    chk_sr(8'h02, 8'h00);
    cmd1(`OP_WRDI);
    chk_sr(8'h00, 8'h00);
  endtask
  task automatic sc_status_nv();
    cmd1(`OP_WREN);
    u_host.tx_q = '{`OP_WRSR, 8'hFF};
    run_job(0, 0, 1, SW_CYC, JOB_WRSR, 0, 0);
    chk_sr(8'hFC, 8'h00);
    cmd1(`OP_WREN);
    u_host.tx_q = '{`OP_WRSR, 8'h00};
    run_job(4, 0, 0, 0, JOB_WRSR, 0, 0);
    chk_sr(8'hFE, 8'h00);
    cmd1(`OP_WRDI);
    run_job(0, 0, 0, 0, JOB_WRSR, 0, 0);
    chk_sr(8'hFC, 8'h00);
  endtask
  task automatic sc_volatile();
    cmd1(`OP_VWREN);
    u_host.tx_q = '{`OP_WRSR, 8'h00, 8'hFF};
    run_job(0, 0, 0, 0, JOB_WRSR, 0, 0);
    chk_sr(8'h00, 8'h42);
    cmd1(`OP_VWREN);
    cmd1(`OP_WRDI);
    u_host.tx_q = '{`OP_WRSR, 8'hFC};
    run_job(0, 0, 0, 0, JOB_WRSR, 0, 0);
    chk_sr(8'h00, 8'h42);
  endtask
  task automatic sc_program();
    logic [15:0] exp_q [5] = '{16'hFEA1, 16'hFFA2, 16'hFFB1, 16'h00B2, 16'h10C3};
    got_q.delete();
    cmd1(`OP_WREN);
    set_in(1'b0, 1'b0);
    u_host.tx_q = '{`OP_PROG, 8'h01, 8'h23, 8'hFE, 8'hA1, 8'hA2};
    run_job(0, 0, 0, PW_CYC, JOB_PROG, 24'hFF_FF00, 24'h01_2300);
    cmp(PROG_VALID, 1'b1, "held byte");
    set_in(1'b1, 1'b0);
    repeat (8) @(posedge CORE_CLK);
    cmd1(`OP_WREN);
    u_host.tx_q = '{`OP_PROG, 8'h01, 8'h23, 8'hFF, 8'hB1, 8'hB2};
    run_job(0, 0, 0, PW_CYC, JOB_PROG, 24'hFF_FF00, 24'h01_2300);
    cmd1(`OP_WREN);
    u_host.tx_q = '{`OP_QPROG, 8'h04, 8'h56, 8'h10, 8'hC3};
    run_job(0, 1, 0, PW_CYC, JOB_PROG, 24'hFF_FF00, 24'h04_5600);
    cmp(got_q.size(), 5, "byte count");
    foreach (exp_q[i]) cmp(got_q[i], exp_q[i], "page byte");
    chk_sr(8'h00, 8'h42);
  endtask
  task automatic sc_erase();
    logic [7:0]  ops [3] = '{`OP_SWIPE, `OP_HWIPE, `OP_BWIPE};
    logic [23:0] msk [3] = '{24'hFF_F000, 24'hFF_8000, 24'hFF_0000};
    job_e        knd [3] = '{JOB_SWIPE, JOB_LWIPE, JOB_LWIPE};
    int          bsy [3] = '{SM_CYC, LG_CYC, LG_CYC};
    for (int i = 0; i < 3; i++)
    begin
      cmd1(`OP_WREN);
      u_host.tx_q = '{ops[i], 8'h0A, 8'hBC, 8'hDE};
      run_job(0, 0, 0, bsy[i], knd[i], msk[i], 24'h0A_BCDE & msk[i]);
      chk_sr(8'h00, 8'h42);
    end
  endtask
  task automatic sc_refuse();
    cmd1(`OP_WREN);
    set_in(1'b1, 1'b1);
    u_host.tx_q = '{`OP_PROG, 8'h01, 8'h23, 8'h00, 8'h11};
    run_job(0, 0, 0, 0, JOB_NONE, 0, 0);
    u_host.tx_q = '{`OP_SWIPE, 8'h01, 8'h23, 8'h00};
    run_job(0, 0, 0, 0, JOB_NONE, 0, 0);
    set_in(1'b1, 1'b0);
    run_job(3, 0, 0, 0, JOB_NONE, 0, 0);
    u_host.tx_q = '{`OP_PROG, 8'h01, 8'h23, 8'h00, 8'h11};
    run_job(5, 0, 0, 0, JOB_NONE, 0, 0);
    cmd1(`OP_WRDI);
    run_job(0, 0, 0, 0, JOB_NONE, 0, 0);
  endtask
  task automatic sc_locks();
    cmd1(`OP_WREN);
    u_host.tx_q = '{`OP_WRSR, 8'h00, 8'h38};
    run_job(0, 0, 0, SW_CYC, JOB_WRSR, 0, 0);
    chk_sr(8'h00, 8'h38);
    cmd1(`OP_WREN);
    u_host.tx_q = '{`OP_WRSR, 8'h00, 8'h00};
    run_job(0, 0, 0, -1, JOB_WRSR, 0, 0);
    chk_sr(8'h00, 8'h38);
    cmd1(`OP_WREN);
    u_host.tx_q = '{`OP_QPROG, 8'h04, 8'h56, 8'h10, 8'hC3};
    run_job(0, 1, 0, 0, JOB_NONE, 0, 0);
  endtask
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence: reset for two cycles, then each scenario
  initial
  begin
    repeat (2) @(posedge CORE_CLK);
    #1 RST_N = 1'b1;
    repeat (6) @(posedge CORE_CLK);
    sc_latch();
    sc_status_nv();
    sc_volatile();
    sc_program();
    sc_erase();
    sc_refuse();
    sc_locks();
    final_report();
  end
  // watchdog: well past the expected run length
  initial
  begin
    #400us;
    fail_count++;
    final_report();
  end
endmodule
